/* hdl/mcuid_decoder.sv */
// Instruction fetch sequencing and field decode for the 8-bit core
`timescale 1ns/10ps
`include "mcuid_defines.svh"
module mcuid_decoder (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Program memory word and execution feedback
  input wire logic [15:0] prog_word,
  input wire logic ext_en,
  input wire logic test_true,
  input wire logic pc_write,
  // Sequencing outputs
  output logic cycle_start,
  output logic nop_cycle,
  output logic second_cycle,
  output logic word2_bad,
  output logic [1:0] osc_phase,
  // Decoded fields
  output mcuid_pkg::mcuid_fields_t dec
);
  logic cycle_en;
  logic [1:0] phase_w;
  logic flush;
  mcuid_pkg::mcuid_st_t st_reg, st_next;

  mcuid_phase #(.PHASES(`MCUID_PHASES)) u_phase (
    .clk(clk),
    .rst(rst),
    .phase(phase_w),
    .cycle_en(cycle_en)
  );

  // Decode one program word; ext words decode as no-operation when disabled
  function automatic mcuid_pkg::mcuid_fields_t mcuid_decode(input logic [15:0] w, input logic ext);
    mcuid_pkg::mcuid_fields_t f;
    f = '0;
    f.cls = mcuid_pkg::CLS_NOP;
    f.tbl_mode = mcuid_pkg::TBL_NONE;
    f.dest_file = w[`MCUID_DEST_BIT];
    f.use_bank = w[`MCUID_ACC_BIT];
    f.file_addr = {4'h0, w[7:0]};
    f.bit_num = w[`MCUID_BIT_HI:`MCUID_BIT_LO];
    f.bit_mask = 8'h01 << w[`MCUID_BIT_HI:`MCUID_BIT_LO];
    f.literal = {4'h0, w[7:0]};
    f.rel_off = {{3{w[7]}}, w[7:0]};
    case (w[15:12])
      `MCUID_GRP_CTRL0:
      begin
        if (w[11])
          f.cls = mcuid_pkg::CLS_LIT;
        else if (w[11:8] == 4'h1)
        begin
          f.cls = mcuid_pkg::CLS_LIT;
          f.literal = {8'h00, w[3:0]};
        end
        else if (w[11:8] != 4'h0)
          f.cls = mcuid_pkg::CLS_BYTE;
        else if (w[7:3] == 5'h01)
        begin
          f.cls = mcuid_pkg::CLS_CTRL;
          f.tbl_op = 1'b1;
          f.tbl_mode = mcuid_pkg::mcuid_tbl_t'(w[1:0]);
        end
        else if (w[7:2] == 6'h04)
        begin
          f.cls = mcuid_pkg::CLS_CTRL;
          f.branch = 1'b1;
          f.shadow_en = w[`MCUID_SHADOW_BIT];
        end
        else if (w[7:0] == 8'h14)
        begin
          f.cls = ext ? mcuid_pkg::CLS_EXT : mcuid_pkg::CLS_NOP;
          f.branch = ext;
        end
        else if (w[7:0] == 8'hFF)
        begin
          f.cls = mcuid_pkg::CLS_CTRL;
          f.branch = 1'b1;
        end
        else if (w[7:0] != 8'h00)
          f.cls = mcuid_pkg::CLS_CTRL;
      end
      4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6:
      begin
        f.cls = mcuid_pkg::CLS_BYTE;
        f.cond = (w[15:10] == 6'h0B) || (w[15:10] == 6'h0F) || (w[15:10] == 6'h12)
               || (w[15:10] == 6'h13) || (w[15:12] == 4'h6 && !w[11]);
      end
      4'h7, 4'h8, 4'h9, 4'hA, 4'hB:
      begin
        f.cls = mcuid_pkg::CLS_BIT;
        f.cond = (w[15:12] == 4'hA) || (w[15:12] == 4'hB);
      end
      `MCUID_GRP_MOVFF:
      begin
        f.cls = mcuid_pkg::CLS_BYTE;
        f.two_word = 1'b1;
        f.file_addr = w[11:0];
      end
      `MCUID_GRP_BRA:
      begin
        f.cls = mcuid_pkg::CLS_CTRL;
        f.branch = 1'b1;
        f.rel_off = w[10:0];
      end
      `MCUID_GRP_E:
      begin
        case (w[11:8])
          `MCUID_SUB_CALL0, `MCUID_SUB_CALL1:
          begin
            f.cls = mcuid_pkg::CLS_CTRL;
            f.two_word = 1'b1;
            f.shadow_en = w[`MCUID_ACC_BIT];
          end
          `MCUID_SUB_LFSR:
          begin
            f.cls = mcuid_pkg::CLS_LIT;
            f.two_word = 1'b1;
            f.ptr_sel = w[5:4];
            f.literal = {w[3:0], 8'h00};
          end
          `MCUID_SUB_GOTO:
          begin
            f.cls = mcuid_pkg::CLS_CTRL;
            f.two_word = 1'b1;
          end
          4'h8, 4'h9, 4'hA, 4'hB:
          begin
            f.cls = ext ? mcuid_pkg::CLS_EXT : mcuid_pkg::CLS_NOP;
            f.ptr_sel = w[7:6];
            f.literal = {6'h00, w[5:0]};
          end
          default:
          begin
            f.cls = mcuid_pkg::CLS_CTRL;
            f.cond = 1'b1;
          end
        endcase
      end
      default:
      begin
        f.cls = mcuid_pkg::CLS_NOP;
      end
    endcase
    return f;
  endfunction

  // Extra NOP cycle when a test is true or the PC is changed
  // taken costs one cycle
  assign flush = st_reg.dec.branch || (st_reg.dec.cond && test_true) || pc_write;

  // Sequencer: next word is taken at the end of each instruction cycle
  always_comb
  begin
    st_next = st_reg;
    st_next.cyc_start = cycle_en;
    st_next.phase = phase_w;
    if (cycle_en)
    begin
      st_next.nop_cycle = 1'b0;
      st_next.second_cycle = 1'b0;
      st_next.word2_bad = 1'b0;
      case (st_reg.state)
        mcuid_pkg::ST_EXEC:
        begin
          if (st_reg.dec.two_word)
          begin
            st_next.state = mcuid_pkg::ST_WORD2;
            st_next.second_cycle = 1'b1;
            st_next.word2_bad = (prog_word[15:12] != `MCUID_W2_PREFIX);
            st_next.dec.file_dst = prog_word[11:0];
            st_next.dec.literal = {st_reg.dec.literal[11:8], prog_word[7:0]};
            st_next.dec.prog_addr = {prog_word[11:0], st_reg.first_word[7:0], 1'b0};
          end
          else if (flush)
          begin
            st_next.state = mcuid_pkg::ST_FLUSH;
            st_next.nop_cycle = 1'b1;
            st_next.dec = '0;
          end
          else
          begin
            st_next.dec = mcuid_decode(prog_word, ext_en);
            st_next.first_word = prog_word;
          end
        end
        mcuid_pkg::ST_WORD2, mcuid_pkg::ST_FLUSH:
        begin
          // A fetched second word here decodes as a NOP, so a skip over it costs one more cycle
          st_next.state = mcuid_pkg::ST_EXEC;
          st_next.dec = mcuid_decode(prog_word, ext_en);
          st_next.first_word = prog_word;
        end
        default:
        begin
          st_next.state = mcuid_pkg::ST_EXEC;
          st_next.dec = '0;
        end
      endcase
    end
  end

  // State and output registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign cycle_start = st_reg.cyc_start;
  assign nop_cycle = st_reg.nop_cycle;
  assign second_cycle = st_reg.second_cycle;
  assign word2_bad = st_reg.word2_bad;
  assign osc_phase = st_reg.phase;
  assign dec = st_reg.dec;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_cycle;
    cycle_start ##1 !cycle_start [*3] ##1 cycle_start;
  endsequence
  sequence s_taken;
    cycle_en && st_reg.state == mcuid_pkg::ST_EXEC && !st_reg.dec.two_word && flush;
  endsequence

  a_cycle_period: assert property (cycle_start |-> s_cycle)
    else $error("instruction cycle is not four clocks");
  a_taken_nop: assert property (s_taken |=> nop_cycle && dec.cls == mcuid_pkg::CLS_NOP)
    else $error("taken instruction not followed by a NOP cycle");
  a_nop_one_cycle: assert property (cycle_start && nop_cycle |-> ##4 cycle_start && !nop_cycle)
    else $error("NOP cycle lasted more than one instruction cycle");
  a_two_word_len: assert property (cycle_en && st_reg.state == mcuid_pkg::ST_EXEC && st_reg.dec.two_word
    |=> second_cycle ##4 !second_cycle)
    else $error("two-word instruction did not take two cycles");
  a_word2_prefix: assert property (cycle_en && st_reg.dec.two_word && st_reg.state == mcuid_pkg::ST_EXEC
    |=> word2_bad == ($past(prog_word[15:12]) != 4'hF))
    else $error("second word prefix flag wrong");
  a_lone_word2: assert property (cycle_en && st_reg.state != mcuid_pkg::ST_EXEC && prog_word[15:12] == 4'hF
    |=> dec.cls == mcuid_pkg::CLS_NOP && !dec.branch && !dec.two_word)
    else $error("lone second word not a NOP");
  a_bit_mask: assert property (dec.cls == mcuid_pkg::CLS_BIT |-> $onehot(dec.bit_mask) && dec.bit_mask[dec.bit_num])
    else $error("bit mask does not match bit number");
  a_dest_bank: assert property (cycle_en && st_reg.state != mcuid_pkg::ST_EXEC
    |=> dec.dest_file == $past(prog_word[9]) && dec.use_bank == $past(prog_word[8]))
    else $error("destination or bank bit not taken from the word");
  a_tbl_mode: assert property (cycle_en && st_reg.state != mcuid_pkg::ST_EXEC && prog_word[15:2] == 14'h0002
    |=> dec.tbl_op && dec.tbl_mode == mcuid_pkg::mcuid_tbl_t'($past(prog_word[1:0])))
    else $error("table mode decoded wrongly");
endmodule

/* hdl/mcuid_defines.svh */
// Constants of the instruction decoder: phases, field positions, opcode groups
// Function
// - Decode the 75 core instructions plus the 8 extended stack instructions.
// - Most instructions are one 16-bit word; exactly four take two words.
// - Destination bit zero writes the working register, one writes the file register.
// - Bit instructions pick a bit of the addressed file register by bit field.
// - Literal instructions carry a literal, sometimes a pointer designator, or nothing.
// - Control instructions carry an address, a call mode bit, a table mode, or nothing.
// - Second word of a two-word instruction has its top four bits all one.
// - A second word executed on its own behaves as a no-operation.
// - One cycle per single word; taken test or PC change adds a NOP cycle.
// - Every two-word instruction takes two instruction cycles.
// - One instruction cycle is four consecutive oscillator periods.
// - Access bit zero uses access RAM, one uses the bank select register.
// - Call mode bit set saves or restores shadow copies; clear leaves them alone.
// - Table mode: program pointer unchanged, post-increment, post-decrement or pre-increment.
`ifndef MCUID_DEFINES_SVH
`define MCUID_DEFINES_SVH
`define MCUID_PHASES 4
`define MCUID_WORD_W 16
`define MCUID_PADDR_W 21
`define MCUID_W2_PREFIX 4'hF
`define MCUID_DEST_BIT 9
`define MCUID_ACC_BIT 8
`define MCUID_BIT_HI 11
`define MCUID_BIT_LO 9
`define MCUID_SHADOW_BIT 0
`define MCUID_GRP_CTRL0 4'h0
`define MCUID_GRP_MOVFF 4'hC
`define MCUID_GRP_BRA 4'hD
`define MCUID_GRP_E 4'hE
`define MCUID_GRP_W2 4'hF
`define MCUID_SUB_CALL0 4'hC
`define MCUID_SUB_CALL1 4'hD
`define MCUID_SUB_LFSR 4'hE
`define MCUID_SUB_GOTO 4'hF
`endif

/* hdl/mcuid_pkg.sv */
// Types shared by the instruction decoder files
package mcuid_pkg;
  typedef enum logic [2:0] {CLS_NOP, CLS_BYTE, CLS_BIT, CLS_LIT, CLS_CTRL, CLS_EXT} mcuid_class_t;
  typedef enum logic [1:0] {TBL_NONE, TBL_POST_INC, TBL_POST_DEC, TBL_PRE_INC} mcuid_tbl_t;
  typedef enum {ST_EXEC, ST_WORD2, ST_FLUSH} mcuid_state_t;
  typedef struct packed {
    mcuid_class_t cls;
    logic two_word;
    logic branch;
    logic cond;
    logic dest_file;
    logic use_bank;
    logic [11:0] file_addr;
    logic [11:0] file_dst;
    logic [2:0] bit_num;
    logic [7:0] bit_mask;
    logic [11:0] literal;
    logic [1:0] ptr_sel;
    logic [10:0] rel_off;
    logic [20:0] prog_addr;
    logic shadow_en;
    logic tbl_op;
    mcuid_tbl_t tbl_mode;
  } mcuid_fields_t;
  typedef struct packed {
    mcuid_state_t state;
    mcuid_fields_t dec;
    logic [15:0] first_word;
    logic cyc_start;
    logic nop_cycle;
    logic second_cycle;
    logic word2_bad;
    logic [1:0] phase;
  } mcuid_st_t;
endpackage

/* hdl/mcuid_phase.sv */
// Oscillator phase divider giving one enable per instruction cycle
`timescale 1ns/10ps
`include "mcuid_defines.svh"
module mcuid_phase #(
  parameter int PHASES = `MCUID_PHASES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Phase outputs
  output logic [1:0] phase,
  output logic cycle_en
);
  // Refuse a phase count that the two-bit counter cannot hold
  if (PHASES < 2 || PHASES > 4)
  begin
    $error("PHASES must be 2 to 4");
  end

  typedef struct packed {
    logic [1:0] cnt;
    logic en;
  } mcuid_ph_t;
  mcuid_ph_t ph_reg, ph_next;

  // Count oscillator periods; the pulse marks the last one of a cycle
  // four-period cycle
  always_comb
  begin
    ph_next = ph_reg;
    ph_next.en = (ph_reg.cnt == 2'(PHASES - 2));
    if (ph_reg.cnt == 2'(PHASES - 1))
      ph_next.cnt = 2'h0;
    else
      ph_next.cnt = ph_reg.cnt + 2'h1;
  end

  // State register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ph_reg <= '0;
    else
      ph_reg <= ph_next;
  end

  assign phase = ph_reg.cnt;
  assign cycle_en = ph_reg.en;
endmodule

/* tb/mcuid_prog_mem.sv */
// Program memory model serving one word per instruction cycle
`timescale 1ns/10ps
module mcuid_prog_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fetch side
  input wire logic cycle_start,
  output logic [15:0] prog_word
);
  logic [15:0] mem [0:63];
  logic [5:0] ptr_reg;
  // Step after each cycle start so the word stands over the sampling edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      ptr_reg <= 6'h00;
    else if (cycle_start)
      ptr_reg <= ptr_reg + 6'h01;
  end
  // Flushed words are still fetched, the decoder must drop them
  assign prog_word = mem[ptr_reg];
endmodule

/* tb/tb_mcuid_decoder.sv */
// Self-checking bench for the instruction decoder
`timescale 1ns/10ps
module tb_mcuid_decoder;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ext_en = 1'b1;
  logic test_true = 1'b0;
  logic pc_write = 1'b0;
  logic [15:0] prog_word;
  logic cycle_start;
  logic nop_cycle;
  logic second_cycle;
  logic word2_bad;
  logic [1:0] osc_phase;
  mcuid_pkg::mcuid_fields_t dec;
  int err_count = 0;
  int checked = 0;
  int ticks = 0;
  int gap;
  logic [15:0] w;
  logic [15:0] prog [0:29] = '{16'hEE2A, 16'hF0BC, 16'hC123, 16'hF456, 16'hF123, 16'hC001, 16'h0456,
    16'h0008, 16'h0009, 16'h000A, 16'h000B, 16'h0013, 16'h0E11, 16'h0012, 16'h0E22, 16'hED34,
    16'hF567, 16'hB000, 16'h0E33, 16'h2400, 16'h0E44, 16'hE800, 16'hE800, 16'hB000, 16'hEF00, 16'hF000,
    16'hD7FF, 16'h0E55, 16'hE6F0, 16'h0E66};

  // Oscillator
  always #5 clk = ~clk;

  mcuid_decoder u_mcuid_decoder (.clk(clk), .rst(rst), .prog_word(prog_word), .ext_en(ext_en),
    .test_true(test_true), .pc_write(pc_write), .cycle_start(cycle_start), .nop_cycle(nop_cycle),
    .second_cycle(second_cycle), .word2_bad(word2_bad), .osc_phase(osc_phase), .dec(dec));
  mcuid_prog_mem u_mcuid_prog_mem (.clk(clk), .rst(rst), .cycle_start(cycle_start), .prog_word(prog_word));

  // Verdict
  task automatic close_out();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Four-state compare so an unknown never matches
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Class compare
  task automatic chk_cls(input mcuid_pkg::mcuid_class_t got, input mcuid_pkg::mcuid_class_t exp);
    chk(21'(got), 21'(exp));
  endtask

  // Feedback goes out on the first edge so it stands at the cycle end edge
  task automatic next_cycle(input logic tt, input logic pw, input logic ee);
    gap = 0;
    do
    begin
      @(posedge clk);
      if (gap == 0)
      begin
        test_true <= tt;
        pc_write <= pw;
        ext_en <= ee;
      end
      #1;
      // Phase counts the oscillator periods of the cycle, the last one ends it
      if (gap < 4)
        chk(21'(osc_phase), 21'(gap));
      gap++;
    end while (cycle_start !== 1'b1 && gap < 9);
    chk(21'(gap), 21'h4);
  endtask

  // Random byte or bit operation
  function automatic logic [15:0] rnd_word();
    logic [15:0] r;
    r = 16'($urandom());
    return r[15] ? {4'h8, r[11:0]} : {6'h09, r[9:0]};
  endfunction

  // Expected class of a random word
  function automatic mcuid_pkg::mcuid_class_t exp_cls(input logic [15:0] x);
    return x[15] ? mcuid_pkg::CLS_BIT : mcuid_pkg::CLS_BYTE;
  endfunction

  // Hang guard, the run needs about 200 clocks
  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 1000)
    begin
      err_count++;
      close_out();
    end
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'hA66D));
    for (int i = 0; i < 64; i++)
      u_mcuid_prog_mem.mem[i] = (i == 0) ? 16'h0E5A : (i < 17) ? rnd_word() : (i < 47) ? prog[i - 17] : 16'h0000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    next_cycle(0, 0, 1);
    chk_cls(dec.cls, mcuid_pkg::CLS_LIT);
    chk(21'(dec.literal[7:0]), 21'h5A);
    $display("test literal done");
    for (int i = 1; i < 17; i++)
    begin
      next_cycle(1'($urandom()), 0, 1);
      w = u_mcuid_prog_mem.mem[i];
      chk_cls(dec.cls, exp_cls(w));
      chk(21'(dec.file_addr[7:0]), 21'(w[7:0]));
      chk(21'(dec.use_bank), 21'(w[8]));
      chk(21'(nop_cycle), 21'h0);
      if (w[15])
      begin
        chk(21'(dec.bit_num), 21'(w[11:9]));
        chk(21'(dec.bit_mask), 21'(8'h01 << w[11:9]));
      end
      else
        chk(21'(dec.dest_file), 21'(w[9]));
    end
    $display("test random fields done");
    next_cycle(0, 0, 1);
    chk(21'(dec.two_word), 21'h1);
    next_cycle(0, 0, 1);
    chk(21'(second_cycle), 21'h1);
    chk(21'(dec.ptr_sel), 21'h2);
    chk(21'(dec.literal), 21'hABC);
    next_cycle(0, 0, 1);
    chk(21'(dec.file_addr), 21'h123);
    next_cycle(0, 0, 1);
    chk(21'(dec.file_dst), 21'h456);
    chk(21'(word2_bad), 21'h0);
    next_cycle(0, 0, 1);
    chk_cls(dec.cls, mcuid_pkg::CLS_NOP);
    chk(21'(second_cycle), 21'h0);
    next_cycle(0, 0, 1);
    next_cycle(0, 0, 1);
    chk(21'(word2_bad), 21'h1);
    $display("test two-word done");
    for (int m = 0; m < 4; m++)
    begin
      next_cycle(0, 0, 1);
      chk(21'(dec.tbl_op), 21'h1);
      chk(21'(dec.tbl_mode), 21'(m));
    end
    for (int s = 1; s >= 0; s--)
    begin
      next_cycle(0, 0, 1);
      chk(21'(dec.shadow_en), 21'(s));
      next_cycle(0, 0, 1);
      chk(21'(nop_cycle), 21'h1);
      chk_cls(dec.cls, mcuid_pkg::CLS_NOP);
    end
    next_cycle(0, 0, 1);
    chk(21'(dec.shadow_en), 21'h1);
    next_cycle(0, 0, 1);
    chk(dec.prog_addr, 21'h0ACE68);
    next_cycle(0, 0, 1);
    chk(21'(nop_cycle), 21'h0);
    $display("test control done");
    // taken skip and program counter write
    next_cycle(1, 0, 1);
    chk(21'(nop_cycle), 21'h1);
    next_cycle(0, 0, 1);
    chk_cls(dec.cls, mcuid_pkg::CLS_BYTE);
    next_cycle(0, 1, 1);
    chk(21'(nop_cycle), 21'h1);
    next_cycle(0, 0, 1);
    chk_cls(dec.cls, mcuid_pkg::CLS_EXT);
    next_cycle(0, 0, 0);
    chk_cls(dec.cls, mcuid_pkg::CLS_NOP);
    next_cycle(0, 0, 1);
    next_cycle(1, 0, 1);
    chk(21'(nop_cycle), 21'h1);
    next_cycle(0, 0, 1);
    chk_cls(dec.cls, mcuid_pkg::CLS_NOP);
    chk(21'(nop_cycle), 21'h0);
    $display("test flush done");
    next_cycle(0, 0, 1);
    chk_cls(dec.cls, mcuid_pkg::CLS_CTRL);
    chk(21'(dec.rel_off), 21'h7FF);
    next_cycle(0, 0, 1);
    chk(21'(nop_cycle), 21'h1);
    next_cycle(0, 0, 1);
    chk(21'(dec.rel_off), 21'h7F0);
    next_cycle(1, 0, 1);
    chk(21'(nop_cycle), 21'h1);
    $display("test branch done");
    close_out();
  end
endmodule
